// [inc/cft_pkg.sv]
// constants shared by the clock fault / die temperature register slice
// assumes a single 100 MHz clock and a byte-wide register port from the serial host engine
//
// Summary of operation
// - writing 1 to temp_read_request starts a reading; it self-clears when done
// - temp_result_valid is 0 while acquiring, 1 once a stored result exists
// - temp_range_code holds the last 4-bit die temperature range, read-only
// - por power-down bit 0 keeps battery POR powered, 1 powers it down
// - 2-bit sample rate field selects 8, 16, 48 or 96 kHz input rate
// - second detector fault auto-recovers when recovery bit 0, latches shutdown when 1
// - first detector fault auto-recovers when recovery bit 0, latches shutdown when 1
// - on clock fault the gain ramps down at 15, 30, 60 or 120 us per dB
// - first detector mutes playback after its 3-bit timeout, reset code 2
// - second detector mutes playback after its own timeout, same scale, reset code 1
// - clock fault 1 and 2 set sticky flags, cleared by reading their register
// - word clock and modulator clock halts set sticky flags cleared on read
package cft_pkg;

  // register offsets
  localparam logic [7:0] ADDR_FLAGS_A  = 8'h26;
  localparam logic [7:0] ADDR_FLAGS_B  = 8'h27;
  localparam logic [7:0] ADDR_DIE_TEMP = 8'h31;
  localparam logic [7:0] ADDR_LOW_PWR  = 8'h35;
  localparam logic [7:0] ADDR_RATE     = 8'h36;
  localparam logic [7:0] ADDR_CFG_A    = 8'h4f;
  localparam logic [7:0] ADDR_CFG_B    = 8'h50;

  // values after reset
  localparam logic [7:0] RST_LOW_PWR = 8'h00;
  localparam logic [7:0] RST_RATE    = 8'h32;
  localparam logic [7:0] RST_CFG_A   = 8'h00;
  localparam logic [7:0] RST_CFG_B   = 8'h11;

  // field positions
  localparam int BIT_TEMP_REQ   = 5;
  localparam int BIT_TEMP_VALID = 4;
  localparam int BIT_POR_PWRDN  = 7;
  localparam int BIT_REC_SECOND = 3;
  localparam int BIT_REC_FIRST  = 2;
  localparam int LSB_RAMP       = 6;
  localparam int LSB_TO_FIRST   = 3;
  localparam int LSB_TO_SECOND  = 0;
  localparam int BIT_FLAG_CLK1  = 5;
  localparam int BIT_FLAG_CLK2  = 2;
  localparam int BIT_FLAG_WCLK  = 7;
  localparam int BIT_FLAG_MCLK  = 6;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FAULT_TO_NS [8] = '{10600, 21300, 42600, 85300,
                                              340000, 680000, 1360000, 2730000};
  localparam int unsigned RAMP_STEP_NS [4] = '{15000, 30000, 60000, 120000};
  localparam int          TO_CNT_W   = 19;
  localparam int          RAMP_CNT_W = 15;
  localparam logic [6:0]  ATTEN_MAX_DB = 7'h7f;

  typedef enum logic {CFT_TEMP_IDLE, CFT_TEMP_BUSY} cft_temp_state_e;

  // least time in ns to whole cycles, never below one
  function automatic int unsigned cft_ns_to_cyc(input int unsigned ns,
                                                input int unsigned per);
    int unsigned c;
    c = (ns + per - 1) / per;
    return (c == 0) ? 1 : c;
  endfunction : cft_ns_to_cyc

endpackage : cft_pkg

// [inc/cft_det_if.sv]
// link between the register slice and one clock fault detector
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface cft_det_if;
  logic [2:0] timeout_code;
  logic       latch_mode;
  logic       user_recover;
  logic       clk_seen;
  logic       fault;
  logic       fault_evt;

  modport det (input timeout_code, latch_mode, user_recover, clk_seen,
               output fault, fault_evt);
  modport ctl (output timeout_code, latch_mode, user_recover, clk_seen,
               input fault, fault_evt);
endinterface : cft_det_if
`default_nettype wire

// [verilog/cft_clk_fault_det.sv]
// missing-clock detector: counts cycles since the watched clock was last seen
// assumes clk_seen is a synchronous one-cycle marker per watched clock edge
`timescale 1ns/10ps
`default_nettype none
module cft_clk_fault_det #(
  parameter int unsigned CLK_PERIOD_NS = cft_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // detector link
  cft_det_if.det    bus
);
  import cft_pkg::*;

  typedef struct packed {
    logic [TO_CNT_W-1:0] cnt;
    logic                fault;
    logic                evt;
  } cft_det_s;

  cft_det_s            q;
  cft_det_s            d;
  logic [TO_CNT_W-1:0] limit;

  // timeout on the internal reference clock
  assign limit = TO_CNT_W'(cft_ns_to_cyc(FAULT_TO_NS[bus.timeout_code], CLK_PERIOD_NS));

  always_comb
  begin
    d     = q;
    d.evt = 1'b0;
    if (bus.clk_seen)
      d.cnt = '0;
    else if (q.cnt < limit)
      d.cnt = q.cnt + 1'b1;
    if (!q.fault && !bus.clk_seen && d.cnt >= limit)
    begin
      d.fault = 1'b1;
      d.evt   = 1'b1;
    end
    else if (q.fault && !bus.latch_mode && bus.clk_seen)
      d.fault = 1'b0;
    else if (q.fault && bus.latch_mode && bus.user_recover)
    begin
      d.fault = 1'b0;
      d.cnt   = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      q <= '0;
    else
      q <= d;
  end

  assign bus.fault     = q.fault;
  assign bus.fault_evt = q.evt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_auto_recovers: assert property (
    bus.fault && !bus.latch_mode && bus.clk_seen |=> !bus.fault)
    else $error("auto recovery did not clear fault");
  a_latched_holds: assert property (
    bus.fault && bus.latch_mode && !bus.user_recover |=> bus.fault)
    else $error("latched fault dropped without user recovery");
  a_fault_needs_silence: assert property (
    $rose(bus.fault) |-> $past(!bus.clk_seen) && bus.fault_evt)
    else $error("fault raised while clock present");
  c_latched_fault: cover property (bus.fault && bus.latch_mode);
endmodule : cft_clk_fault_det
`default_nettype wire

// [verilog/cft_clock_fault_temp_regs.sv]
// clock fault, die temperature, power and sample rate control registers
// assumes a byte register port decoded by the serial host engine, one access per strobe
`timescale 1ns/10ps
`default_nettype none
module cft_clock_fault_temp_regs #(
  parameter int unsigned CLK_PERIOD_NS = cft_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_en_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_en_i,
  output logic      [7:0] reg_rdata_o,
  // die temperature sensor
  output logic            temp_start_o,
  input  wire logic       temp_done_i,
  input  wire logic [3:0] temp_code_i,
  // power and audio input control
  output logic            por_power_down_o,
  output logic      [1:0] sample_rate_o,
  // clock supervision
  input  wire logic [1:0] fault_clk_seen_i,
  input  wire logic       word_clock_halt_i,
  input  wire logic       modulator_clock_halt_i,
  output logic      [1:0] fault_active_o,
  output logic            playback_mute_o,
  output logic      [6:0] gain_atten_db_o
);
  import cft_pkg::*;

  typedef struct packed {
    logic [7:0]          low_pwr;
    logic [7:0]          rate;
    logic [7:0]          cfg_a;
    logic [7:0]          cfg_b;
    logic [1:0]          temp_rsvd;
    cft_temp_state_e     temp_st;
    logic                temp_valid;
    logic [3:0]          temp_code;
    logic                temp_start;
    logic                flag_clk1;
    logic                flag_clk2;
    logic                flag_wclk;
    logic                flag_mclk;
    logic [7:0]          rdata;
    logic [6:0]          atten;
    logic [RAMP_CNT_W-1:0] ramp_cnt;
  } cft_regs_s;

  cft_regs_s             q;
  cft_regs_s             d;
  logic [1:0]            fault;
  logic [1:0]            fault_evt;
  logic                  any_fault;
  logic                  wr_cfg_a;
  logic [RAMP_CNT_W-1:0] ramp_limit;

  function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] r);
    return en && (a == r);
  endfunction : hit

  assign wr_cfg_a = hit(reg_wr_en_i, reg_addr_i, ADDR_CFG_A);

  // two detectors: index 0 first, index 1 second
  cft_det_if det_if [2] ();

  for (genvar g = 0; g < 2; g++)
  begin : g_det
    cft_clk_fault_det #(
      .CLK_PERIOD_NS (CLK_PERIOD_NS)
    ) u_det (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .bus     (det_if[g])
    );
    assign det_if[g].clk_seen     = fault_clk_seen_i[g];
    assign det_if[g].user_recover = wr_cfg_a;
    assign fault[g]               = det_if[g].fault;
    assign fault_evt[g]           = det_if[g].fault_evt;
  end

  assign det_if[0].timeout_code = q.cfg_b[LSB_TO_FIRST +: 3];
  assign det_if[1].timeout_code = q.cfg_b[LSB_TO_SECOND +: 3];
  assign det_if[0].latch_mode   = q.cfg_a[BIT_REC_FIRST];
  assign det_if[1].latch_mode   = q.cfg_a[BIT_REC_SECOND];
  assign any_fault              = |fault;

  // gain ramp step period
  assign ramp_limit = RAMP_CNT_W'(cft_ns_to_cyc(RAMP_STEP_NS[q.cfg_b[LSB_RAMP +: 2]],
                                                CLK_PERIOD_NS));

  always_comb
  begin
    logic rd_a;
    logic rd_b;
    d            = q;
    d.temp_start = 1'b0;
    rd_a         = hit(reg_rd_en_i, reg_addr_i, ADDR_FLAGS_A);
    rd_b         = hit(reg_rd_en_i, reg_addr_i, ADDR_FLAGS_B);

    // writes
    if (reg_wr_en_i)
    begin
      unique case (reg_addr_i)
        ADDR_LOW_PWR: d.low_pwr = reg_wdata_i;
        ADDR_RATE:    d.rate    = reg_wdata_i;
        ADDR_CFG_A:   d.cfg_a   = reg_wdata_i;
        ADDR_CFG_B:   d.cfg_b   = reg_wdata_i;
        ADDR_DIE_TEMP:
        begin
          d.temp_rsvd = reg_wdata_i[7:6];
          if (reg_wdata_i[BIT_TEMP_REQ] && q.temp_st == CFT_TEMP_IDLE)
          begin
            d.temp_st    = CFT_TEMP_BUSY;
            d.temp_start = 1'b1;
            d.temp_valid = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // acquisition completion
    if (q.temp_st == CFT_TEMP_BUSY && temp_done_i)
    begin
      d.temp_st    = CFT_TEMP_IDLE;
      d.temp_valid = 1'b1;
      d.temp_code  = temp_code_i;
    end

    // sticky flags: clear on read, set wins
    d.flag_clk1 = (q.flag_clk1 && !rd_a) || fault_evt[0];
    d.flag_clk2 = (q.flag_clk2 && !rd_a) || fault_evt[1];
    d.flag_wclk = (q.flag_wclk && !rd_b) || word_clock_halt_i;
    d.flag_mclk = (q.flag_mclk && !rd_b) || modulator_clock_halt_i;

    // read data
    if (reg_rd_en_i)
    begin
      unique case (reg_addr_i)
        ADDR_FLAGS_A:
        begin
          d.rdata                = 8'h00;
          d.rdata[BIT_FLAG_CLK1] = q.flag_clk1;
          d.rdata[BIT_FLAG_CLK2] = q.flag_clk2;
        end
        ADDR_FLAGS_B:
        begin
          d.rdata                = 8'h00;
          d.rdata[BIT_FLAG_WCLK] = q.flag_wclk;
          d.rdata[BIT_FLAG_MCLK] = q.flag_mclk;
        end
        ADDR_DIE_TEMP: d.rdata = {q.temp_rsvd, q.temp_st == CFT_TEMP_BUSY,
                                  q.temp_valid, q.temp_code};
        ADDR_LOW_PWR:  d.rdata = q.low_pwr;
        ADDR_RATE:     d.rdata = q.rate;
        ADDR_CFG_A:    d.rdata = q.cfg_a;
        ADDR_CFG_B:    d.rdata = q.cfg_b;
        default:       d.rdata = 8'h00;
      endcase
    end

    // gain ramp down on fault, back up after recovery
    if ((any_fault && q.atten != ATTEN_MAX_DB) || (!any_fault && q.atten != 7'h00))
    begin
      if (q.ramp_cnt >= ramp_limit - 1'b1)
      begin
        d.ramp_cnt = '0;
        d.atten    = any_fault ? q.atten + 7'h01 : q.atten - 7'h01;
      end
      else
        d.ramp_cnt = q.ramp_cnt + 1'b1;
    end
    else
      d.ramp_cnt = '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q         <= '0;
      q.low_pwr <= RST_LOW_PWR;
      q.rate    <= RST_RATE;
      q.cfg_a   <= RST_CFG_A;
      q.cfg_b   <= RST_CFG_B;
      q.temp_st <= CFT_TEMP_IDLE;
    end
    else
      q <= d;
  end

  assign reg_rdata_o      = q.rdata;
  assign temp_start_o     = q.temp_start;
  assign por_power_down_o = q.low_pwr[BIT_POR_PWRDN];
  assign sample_rate_o    = q.rate[1:0];
  assign fault_active_o   = fault;
  assign playback_mute_o  = any_fault;
  assign gain_atten_db_o  = q.atten;

  // cycles the attenuation has stood still while a fault ramp-down step is due
  logic [6:0]            atten_seen_q;
  logic [RAMP_CNT_W-1:0] atten_stall_q;

  always_ff @(posedge clk_i)
  begin
    atten_seen_q <= q.atten;
    if (!rst_n_i || !any_fault || q.atten == ATTEN_MAX_DB || q.atten != atten_seen_q)
      atten_stall_q <= '0;
    else if (atten_stall_q != '1)
      atten_stall_q <= atten_stall_q + 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_temp_request_start: assert property (
    hit(reg_wr_en_i, reg_addr_i, ADDR_DIE_TEMP) && reg_wdata_i[BIT_TEMP_REQ]
    && q.temp_st == CFT_TEMP_IDLE |=> temp_start_o ##1 !temp_start_o)
    else $error("temperature request did not start one acquisition");
  a_temp_self_clear: assert property (
    q.temp_st == CFT_TEMP_BUSY && temp_done_i |=> q.temp_st == CFT_TEMP_IDLE)
    else $error("request bit did not clear on completion");
  a_valid_low_busy: assert property (
    q.temp_st == CFT_TEMP_BUSY |-> !q.temp_valid)
    else $error("valid flag high during acquisition");
  a_temp_code_stored: assert property (
    q.temp_st == CFT_TEMP_BUSY && temp_done_i |=> q.temp_code == $past(temp_code_i)
    && q.temp_valid)
    else $error("temperature code not captured");
  a_por_write_follows: assert property (
    hit(reg_wr_en_i, reg_addr_i, ADDR_LOW_PWR)
    |=> por_power_down_o == $past(reg_wdata_i[BIT_POR_PWRDN]))
    else $error("por control did not follow write");
  a_rate_write_follows: assert property (
    hit(reg_wr_en_i, reg_addr_i, ADDR_RATE) |=> sample_rate_o == $past(reg_wdata_i[1:0]))
    else $error("sample rate did not follow write");
  a_flag_set_wins: assert property (
    fault_evt[0] |=> q.flag_clk1)
    else $error("clock fault flag lost");
  a_flag_sticky_hold: assert property (
    q.flag_wclk && !hit(reg_rd_en_i, reg_addr_i, ADDR_FLAGS_B) |=> q.flag_wclk)
    else $error("halt flag dropped without read");
  a_atten_ramps_down: assert property (
    atten_stall_q <= ramp_limit)
    else $error("gain not ramping during fault");
  a_atten_restores: assert property (
    !any_fault |=> q.atten <= $past(q.atten))
    else $error("gain attenuation rose without fault");

  c_temp_done: cover property (q.temp_st == CFT_TEMP_BUSY ##1 q.temp_valid);
  c_full_mute: cover property (q.atten == ATTEN_MAX_DB);
  c_flag_read: cover property (q.flag_clk2 && hit(reg_rd_en_i, reg_addr_i, ADDR_FLAGS_A));
endmodule : cft_clock_fault_temp_regs
`default_nettype wire

// [tb/cft_temp_sensor_model.sv]
// die temperature sensor stand-in: answers each start pulse after a fixed delay
// assumes the start pulse is one cycle wide and synchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
module cft_temp_sensor_model #(
  parameter int         LAT  = 4,
  parameter logic [3:0] CODE = 4'h9
) (
  // clock
  input  wire logic       clk_i,
  // sensor handshake
  input  wire logic       start_i,
  output logic            done_o,
  output logic      [3:0] code_o
);
  int cnt = 0;
  // code is only meaningful with done; otherwise show its inverse
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    code_o <= ~CODE;
    if (start_i)
      cnt <= LAT;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        done_o <= 1'b1;
        code_o <= CODE;
      end
    end
  end
endmodule : cft_temp_sensor_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the clock fault / die temperature register slice
// assumes the byte register port and a sensor model on the temperature handshake
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cft_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic       reg_wr_en_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_rd_en_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       temp_start_o;
  logic       temp_done_i;
  logic [3:0] temp_code_i;
  logic       por_power_down_o;
  logic [1:0] sample_rate_o;
  logic [1:0] fault_clk_seen_i = 2'h3;
  logic       word_clock_halt_i = 1'b0;
  logic       modulator_clock_halt_i = 1'b0;
  logic [1:0] fault_active_o;
  logic       playback_mute_o;
  logic [6:0] gain_atten_db_o;
  int         n_mismatch = 0;
  int         comparisons = 0;
  logic [7:0] rv;

  always #5 clk_i = ~clk_i;

  cft_clock_fault_temp_regs #(.CLK_PERIOD_NS(1000)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_en_i(reg_wr_en_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_en_i(reg_rd_en_i), .reg_rdata_o(reg_rdata_o),
    .temp_start_o(temp_start_o), .temp_done_i(temp_done_i), .temp_code_i(temp_code_i),
    .por_power_down_o(por_power_down_o), .sample_rate_o(sample_rate_o),
    .fault_clk_seen_i(fault_clk_seen_i), .word_clock_halt_i(word_clock_halt_i),
    .modulator_clock_halt_i(modulator_clock_halt_i), .fault_active_o(fault_active_o),
    .playback_mute_o(playback_mute_o), .gain_atten_db_o(gain_atten_db_o));

  cft_temp_sensor_model #(.LAT(4), .CODE(4'h9)) sensor (
    .clk_i(clk_i), .start_i(temp_start_o), .done_o(temp_done_i), .code_o(temp_code_i));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_en_i = 1'b1;
    cyc(1);
    reg_wr_en_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cyc(1);
    reg_addr_i = a;
    reg_rd_en_i = 1'b1;
    cyc(1);
    reg_rd_en_i = 1'b0;
    d = reg_rdata_o;
  endtask : rd

  task automatic t_reset_and_config;
    rd(ADDR_LOW_PWR, rv);
    chk(rv, RST_LOW_PWR);
    rd(ADDR_RATE, rv);
    chk(rv, RST_RATE);
    rd(ADDR_CFG_A, rv);
    chk(rv, RST_CFG_A);
    rd(ADDR_CFG_B, rv);
    chk(rv, RST_CFG_B);
    rd(ADDR_DIE_TEMP, rv);
    chk(rv, 8'h00);
    chk({6'h00, sample_rate_o}, 8'h02);
    wr(8'h40, 8'hff);
    rd(8'h40, rv);
    chk(rv, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_RATE, 8'h30 | 8'(i));
      chk({6'h00, sample_rate_o}, 8'(i));
    end
    wr(ADDR_LOW_PWR, 8'h80);
    chk({7'h00, por_power_down_o}, 8'h01);
    rd(ADDR_LOW_PWR, rv);
    chk(rv, 8'h80);
    wr(ADDR_LOW_PWR, 8'h00);
    chk({7'h00, por_power_down_o}, 8'h00);
    $display("test reset_and_config done");
  endtask : t_reset_and_config

  task automatic t_temperature;
    wr(ADDR_DIE_TEMP, 8'h20);
    rd(ADDR_DIE_TEMP, rv);
    chk(rv, 8'h20);
    cyc(8);
    rd(ADDR_DIE_TEMP, rv);
    chk(rv, 8'h19);
    wr(ADDR_DIE_TEMP, 8'hc0);
    rd(ADDR_DIE_TEMP, rv);
    chk(rv, 8'hd9);
    wr(ADDR_DIE_TEMP, 8'he0);
    rd(ADDR_DIE_TEMP, rv);
    chk(rv, 8'he9);
    cyc(8);
    rd(ADDR_DIE_TEMP, rv);
    chk(rv, 8'hd9);
    $display("test temperature done");
  endtask : t_temperature

  task automatic wait_fault(input logic [1:0] exp);
    int n;
    n = 0;
    while (fault_active_o !== exp && n < 40)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_fault

  task automatic t_fault_auto;
    wr(ADDR_CFG_B, 8'h00);
    rd(ADDR_CFG_B, rv);
    chk(rv, 8'h00);
    fault_clk_seen_i = 2'h2;
    cyc(10);
    chk({6'h00, fault_active_o}, 8'h00);
    cyc(1);
    chk({6'h00, fault_active_o}, 8'h01);
    chk({7'h00, playback_mute_o}, 8'h01);
    cyc(14);
    chk({1'b0, gain_atten_db_o}, 8'h00);
    cyc(1);
    chk({1'b0, gain_atten_db_o}, 8'h01);
    cyc(25);
    chk({1'b0, gain_atten_db_o}, 8'h02);
    fault_clk_seen_i = 2'h3;
    wait_fault(2'h0);
    chk({6'h00, fault_active_o}, 8'h00);
    for (int n = 0; n < 400 && gain_atten_db_o !== 7'h00; n++)
      cyc(1);
    chk({1'b0, gain_atten_db_o}, 8'h00);
    rd(ADDR_FLAGS_A, rv);
    chk(rv, 8'h20);
    rd(ADDR_FLAGS_A, rv);
    chk(rv, 8'h00);
    $display("test fault_auto done");
  endtask : t_fault_auto

  task automatic t_fault_latched;
    wr(ADDR_CFG_A, 8'h08);
    wr(ADDR_CFG_B, 8'h41);
    fault_clk_seen_i = 2'h1;
    cyc(21);
    chk({6'h00, fault_active_o}, 8'h00);
    cyc(1);
    chk({6'h00, fault_active_o}, 8'h02);
    fault_clk_seen_i = 2'h3;
    cyc(29);
    chk({6'h00, fault_active_o}, 8'h02);
    chk({7'h00, playback_mute_o}, 8'h01);
    chk({1'b0, gain_atten_db_o}, 8'h00);
    cyc(1);
    chk({1'b0, gain_atten_db_o}, 8'h01);
    wr(ADDR_CFG_A, 8'h08);
    wait_fault(2'h0);
    chk({6'h00, fault_active_o}, 8'h00);
    rd(ADDR_FLAGS_A, rv);
    chk(rv, 8'h04);
    $display("test fault_latched done");
  endtask : t_fault_latched

  task automatic t_halt_flags;
    word_clock_halt_i = 1'b1;
    cyc(1);
    word_clock_halt_i = 1'b0;
    modulator_clock_halt_i = 1'b1;
    cyc(1);
    modulator_clock_halt_i = 1'b0;
    rd(ADDR_FLAGS_B, rv);
    chk(rv, 8'hc0);
    rd(ADDR_FLAGS_B, rv);
    chk(rv, 8'h00);
    $display("test halt_flags done");
  endtask : t_halt_flags

  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (6) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset_and_config();
    t_temperature();
    t_fault_auto();
    t_fault_latched();
    t_halt_flags();
    final_report();
  end

  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule : tb
`default_nettype wire
